//--- llj_pkg.sv
// Package with shared constants and types for the load limit judge.
`default_nettype none
package llj_pkg;
  // Width of the signed load value and every threshold.
  localparam int VALUE_WIDTH = 24;
  // Reset value of every judgment output (inactive).
  localparam logic JUDGE_RESET = 1'b0;
  // A deadband width of this value switches hysteresis off.
  localparam logic [VALUE_WIDTH-1:0] DEADBAND_OFF = 24'h000000;
  // Judgment criterion selection.
  typedef enum logic {
    LLJ_CRIT_NONE,
    LLJ_CRIT_LOAD
  } llj_crit_type;
endpackage : llj_pkg
`default_nettype wire

//--- llj_cmp_if.sv
// Interface that carries one limit comparison between judge modules.
`default_nettype none
interface llj_cmp_if #(
  parameter int W = 24
);
  logic signed [W-1:0] sample;     // Captured load value.
  logic signed [W-1:0] threshold;  // Limit to compare against.
  logic signed [W-1:0] deadband;   // Shared deadband width.
  logic                holdOn;     // Hysteresis is in force.
  logic                isUpper;    // Upper-type limit when high.
  logic                prevState;  // Current judgment state.
  logic                nextState;  // Computed judgment state.
  modport judge (input sample, threshold, deadband, holdOn, isUpper,
                 prevState, output nextState);
  modport user (output sample, threshold, deadband, holdOn, isUpper,
                prevState, input nextState);
endinterface : llj_cmp_if
`default_nettype wire

//--- llj_limit_cmp.sv
// One limit comparator with optional hold-until-release hysteresis.
`default_nettype none
module llj_limit_cmp (
  llj_cmp_if.judge cmp
);
  // Short name for the value width used in the widening below.
  localparam int VW = llj_pkg::VALUE_WIDTH;
  // Values widened by two bits, so a limit plus or minus a band of any
  // width never wraps around at the range ends.
  logic signed [VW+1:0] sampleWide;     // Sign-extended load value.
  logic signed [VW+1:0] thresholdWide;  // Sign-extended limit.
  logic signed [VW+1:0] bandWide;       // Zero-extended band width.
  logic signed [VW+1:0] releaseLevel;   // Level at which a hold ends.
  logic                 plainOn;        // Plain strict comparison.
  logic                 heldOn;         // Hold-until-release result.

  // The band is a magnitude, so it is zero-extended, never sign-extended.
  assign sampleWide    = {{2{cmp.sample[VW-1]}}, cmp.sample};
  assign thresholdWide = {{2{cmp.threshold[VW-1]}}, cmp.threshold};
  assign bandWide      = {2'b00, cmp.deadband};

  // Upper: release below threshold minus band; lower: above plus band.
  assign releaseLevel = cmp.isUpper ? (thresholdWide - bandWide)
                                    : (thresholdWide + bandWide);

  // Plain strict comparison.
  assign plainOn = cmp.isUpper ? (cmp.sample > cmp.threshold)  // [RULE1]
                               : (cmp.sample < cmp.threshold); // [RULE2]

  // With hysteresis in force, a set output stays set until the value crosses the release level.
  // Both operands are signed, so negative loads compare correctly.
  assign heldOn = cmp.prevState && cmp.holdOn && (cmp.isUpper
      ? !(sampleWide < releaseLevel)                           // [RULE7]
      : !(sampleWide > releaseLevel));                         // [RULE8]

  // Combined judgment of this limit.
  assign cmp.nextState = plainOn || heldOn;
endmodule : llj_limit_cmp
`default_nettype wire

//--- llj_load_limit_judge.sv
// Top of the load limit judge: captures samples and drives judgments.
//
// Behaviour
// [RULE1] Upper outputs set when value above limit.
// [RULE2] Lower outputs set when value below limit.
// [RULE3] Software keeps limits ordered outer to inner.
// [RULE4] Outer pair can be disabled, outputs off.
// [RULE5] Hysteresis only with constant judgment enabled.
// [RULE6] Zero deadband width switches hysteresis off.
// [RULE7] Upper holds until below limit minus band.
// [RULE8] Lower holds until above limit plus band.
// [RULE9] Outer limits hold the same way.
// [RULE10] One deadband width shared by all limits.
// [RULE11] Plain inner comparison overrides held result.
// [RULE12] Criterion none keeps all outputs inactive.
// [RULE13] Load criterion judges the captured held value.
// [RULE14] Judge on sample strobe, outputs next edge.
`default_nettype none
module llj_load_limit_judge #(
  parameter int W = llj_pkg::VALUE_WIDTH
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 sampleValid,
  input  wire logic signed [W-1:0]  loadValue,
  input  wire logic                 critLoad,
  input  wire logic                 constantJudge,
  input  wire logic                 outerEnable,
  input  wire logic signed [W-1:0]  upperThreshold,
  input  wire logic signed [W-1:0]  bottomThreshold,
  input  wire logic signed [W-1:0]  outerUpperThreshold,
  input  wire logic signed [W-1:0]  outerBottomThreshold,
  input  wire logic        [W-1:0]  deadbandWidth,
  output var  logic                 upperJudge_q,
  output var  logic                 bottomJudge_q,
  output var  logic                 outerUpperJudge_q,
  output var  logic                 outerBottomJudge_q,
  output var  logic                 judgeValid_q
);
  // Criterion selected from the plain control port.
  llj_pkg::llj_crit_type crit;
  // Hysteresis is in force only with constant judging and a nonzero band.
  logic                  holdOn;
  // Four comparator links, one per limit.
  llj_cmp_if #(.W(W)) cmpUp ();
  llj_cmp_if #(.W(W)) cmpBot ();
  llj_cmp_if #(.W(W)) cmpOutUp ();
  llj_cmp_if #(.W(W)) cmpOutBot ();
  // Next values of the judgment outputs.
  logic upperJudge_d;
  logic bottomJudge_d;
  logic outerUpperJudge_d;
  logic outerBottomJudge_d;
  logic judgeValid_d;

  // Criterion decode.
  assign crit = critLoad ? llj_pkg::LLJ_CRIT_LOAD : llj_pkg::LLJ_CRIT_NONE;

  // Hysteresis enable combines the option and the band width.
  assign holdOn = constantJudge                              // [RULE5]
      && (deadbandWidth != llj_pkg::DEADBAND_OFF);           // [RULE6]

  // Upper limit comparator; the strobe-time load value is judged.
  assign cmpUp.sample    = loadValue;                        // [RULE13]
  assign cmpUp.threshold = upperThreshold;
  assign cmpUp.deadband  = $signed(deadbandWidth);           // [RULE10]
  assign cmpUp.holdOn    = holdOn;
  assign cmpUp.isUpper   = 1'b1;
  assign cmpUp.prevState = upperJudge_q;
  llj_limit_cmp uUp (.cmp(cmpUp));

  // Lower limit comparator.
  assign cmpBot.sample    = loadValue;
  assign cmpBot.threshold = bottomThreshold;
  assign cmpBot.deadband  = $signed(deadbandWidth);          // [RULE10]
  assign cmpBot.holdOn    = holdOn;
  assign cmpBot.isUpper   = 1'b0;
  assign cmpBot.prevState = bottomJudge_q;
  llj_limit_cmp uBot (.cmp(cmpBot));

  // Outer upper comparator, using its own threshold.
  assign cmpOutUp.sample    = loadValue;
  assign cmpOutUp.threshold = outerUpperThreshold;           // [RULE9]
  assign cmpOutUp.deadband  = $signed(deadbandWidth);        // [RULE10]
  assign cmpOutUp.holdOn    = holdOn;
  assign cmpOutUp.isUpper   = 1'b1;
  assign cmpOutUp.prevState = outerUpperJudge_q;
  llj_limit_cmp uOutUp (.cmp(cmpOutUp));

  // Outer lower comparator, using its own threshold.
  assign cmpOutBot.sample    = loadValue;
  assign cmpOutBot.threshold = outerBottomThreshold;         // [RULE9]
  assign cmpOutBot.deadband  = $signed(deadbandWidth);       // [RULE10]
  assign cmpOutBot.holdOn    = holdOn;
  assign cmpOutBot.isUpper   = 1'b0;
  assign cmpOutBot.prevState = outerBottomJudge_q;
  llj_limit_cmp uOutBot (.cmp(cmpOutBot));

  // An inner held result is dropped when the plain opposite comparison
  // fires, since the plain inner judgment takes precedence.
  assign upperJudge_d = (crit == llj_pkg::LLJ_CRIT_LOAD)     // [RULE12]
      && cmpUp.nextState
      && !(loadValue < bottomThreshold);                     // [RULE11]
  assign bottomJudge_d = (crit == llj_pkg::LLJ_CRIT_LOAD)    // [RULE12]
      && cmpBot.nextState
      && !(loadValue > upperThreshold);                      // [RULE11]
  // Outer outputs stay off while the outer pair is disabled.
  assign outerUpperJudge_d = (crit == llj_pkg::LLJ_CRIT_LOAD)
      && outerEnable && cmpOutUp.nextState;                  // [RULE4]
  assign outerBottomJudge_d = (crit == llj_pkg::LLJ_CRIT_LOAD)
      && outerEnable && cmpOutBot.nextState;                 // [RULE4]
  // A pulse marks the edge on which a judgment was taken.
  assign judgeValid_d = sampleValid && (crit == llj_pkg::LLJ_CRIT_LOAD);

  // Outputs update only on a sample strobe, one edge later.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upperJudge_q       <= llj_pkg::JUDGE_RESET;
      bottomJudge_q      <= llj_pkg::JUDGE_RESET;
      outerUpperJudge_q  <= llj_pkg::JUDGE_RESET;
      outerBottomJudge_q <= llj_pkg::JUDGE_RESET;
    end else if (sampleValid) begin                          // [RULE14]
      upperJudge_q       <= upperJudge_d;
      bottomJudge_q      <= bottomJudge_d;
      outerUpperJudge_q  <= outerUpperJudge_d;
      outerBottomJudge_q <= outerBottomJudge_d;
    end
  end

  // Valid pulse register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      judgeValid_q <= 1'b0;
    end else begin
      judgeValid_q <= judgeValid_d;
    end
  end

  // Assertions next to the judgment logic.
  // Widened copies let the band arithmetic run without overflow, even
  // with a band near its full range and a limit near the range ends.
  logic signed [W+1:0] loadWide;         // Sign-extended load value.
  logic signed [W+1:0] bandWide;         // Zero-extended band width.
  logic signed [W+1:0] upperRelease;     // Upper limit minus band.
  logic signed [W+1:0] bottomRelease;    // Lower limit plus band.
  logic signed [W+1:0] outerUpRelease;   // Outer upper limit minus band.
  logic signed [W+1:0] outerBotRelease;  // Outer lower limit plus band.

  // Release levels worked out from the port values alone.
  assign loadWide        = {{2{loadValue[W-1]}}, loadValue};
  assign bandWide        = {2'b00, deadbandWidth};
  assign upperRelease    = {{2{upperThreshold[W-1]}}, upperThreshold}
                           - bandWide;
  assign bottomRelease   = {{2{bottomThreshold[W-1]}}, bottomThreshold}
                           + bandWide;
  assign outerUpRelease  = {{2{outerUpperThreshold[W-1]}},
                            outerUpperThreshold} - bandWide;
  assign outerBotRelease = {{2{outerBottomThreshold[W-1]}},
                            outerBottomThreshold} + bandWide;

  // All checks run on the system clock and pause during reset.
  default clocking cbAsrt @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // A strobe with a value above the upper limit sets the upper output.
  sequence sUpperHit;
    sampleValid && critLoad && (loadValue > upperThreshold);
  endsequence
  upper_set_a: assert property (sUpperHit |=> upperJudge_q) // [RULE1]
    else $error("Upper output not set above upper limit.");

  // A strobe with a value below the lower limit sets the lower output.
  lower_set_a: assert property ( // [RULE2]
    sampleValid && critLoad && (loadValue < bottomThreshold)
    |=> bottomJudge_q)
    else $error("Lower output not set below lower limit.");

  // A strobe above the enabled outer upper limit sets its output.
  outer_up_set_a: assert property ( // [RULE1]
    sampleValid && critLoad && outerEnable
    && (loadValue > outerUpperThreshold)
    |=> outerUpperJudge_q)
    else $error("Outer upper output not set above its limit.");

  // A strobe below the enabled outer lower limit sets its output.
  outer_bot_set_a: assert property ( // [RULE2]
    sampleValid && critLoad && outerEnable
    && (loadValue < outerBottomThreshold)
    |=> outerBottomJudge_q)
    else $error("Outer lower output not set below its limit.");

  // Disabled outer pair keeps both outer outputs off.
  outer_disable_a: assert property ( // [RULE4]
    sampleValid && !outerEnable
    |=> !outerUpperJudge_q && !outerBottomJudge_q)
    else $error("Outer output active while outer pair disabled.");

  // Without constant judging the upper output follows the plain test.
  no_hyst_a: assert property ( // [RULE5]
    sampleValid && critLoad && !constantJudge
    |=> upperJudge_q == $past(loadValue > upperThreshold))
    else $error("Upper output held without constant judgment.");

  // Without constant judging the outer lower output is plain as well.
  no_hyst_outer_a: assert property ( // [RULE5]
    sampleValid && critLoad && outerEnable && !constantJudge
    |=> outerBottomJudge_q == $past(loadValue < outerBottomThreshold))
    else $error("Outer lower output held without constant judgment.");

  // Zero band behaves as a plain lower comparison.
  zero_band_a: assert property ( // [RULE6]
    sampleValid && critLoad && (deadbandWidth == llj_pkg::DEADBAND_OFF)
    |=> bottomJudge_q == $past(loadValue < bottomThreshold))
    else $error("Lower output held with zero band.");

  // Zero band also makes the upper output a plain comparison.
  zero_band_up_a: assert property ( // [RULE6]
    sampleValid && critLoad && (deadbandWidth == llj_pkg::DEADBAND_OFF)
    |=> upperJudge_q == $past(loadValue > upperThreshold))
    else $error("Upper output held with zero band.");

  // A held upper output survives a sample just inside the band.
  sequence sUpperInBand;
    sampleValid && critLoad && holdOn && upperJudge_q
    && !(loadValue < bottomThreshold) && (loadWide >= upperRelease);
  endsequence
  upper_hold_a: assert property (sUpperInBand |=> upperJudge_q) // [RULE7]
    else $error("Upper output released inside the band.");

  // A sample below the upper release level always clears the output.
  upper_release_a: assert property ( // [RULE7]
    sampleValid && (loadWide < upperRelease) |=> !upperJudge_q)
    else $error("Upper output kept below its release level.");

  // A held lower output survives a sample just inside the band.
  lower_hold_a: assert property ( // [RULE8]
    sampleValid && critLoad && holdOn && bottomJudge_q
    && !(loadValue > upperThreshold) && (loadWide <= bottomRelease)
    |=> bottomJudge_q)
    else $error("Lower output released inside the band.");

  // A sample above the lower release level always clears the output.
  lower_release_a: assert property ( // [RULE8]
    sampleValid && (loadWide > bottomRelease) |=> !bottomJudge_q)
    else $error("Lower output kept above its release level.");

  // A held outer upper output survives a sample inside the band.
  sequence sOuterUpInBand;
    sampleValid && critLoad && holdOn && outerEnable && outerUpperJudge_q
    && (loadWide >= outerUpRelease);
  endsequence
  outer_up_hold_a: assert property ( // [RULE9]
    sOuterUpInBand |=> outerUpperJudge_q)
    else $error("Outer upper output released inside the band.");

  // A held outer lower output survives a sample inside the band.
  sequence sOuterBotInBand;
    sampleValid && critLoad && holdOn && outerEnable && outerBottomJudge_q
    && (loadWide <= outerBotRelease);
  endsequence
  outer_bot_hold_a: assert property ( // [RULE9]
    sOuterBotInBand |=> outerBottomJudge_q)
    else $error("Outer lower output released inside the band.");

  // Outer outputs clear once the sample passes their release levels.
  outer_release_a: assert property ( // [RULE9]
    sampleValid && (loadWide < outerUpRelease) |=> !outerUpperJudge_q)
    else $error("Outer upper output kept below its release level.");
  outer_bot_rel_a: assert property ( // [RULE9]
    sampleValid && (loadWide > outerBotRelease) |=> !outerBottomJudge_q)
    else $error("Outer lower output kept above its release level.");

  // Plain lower comparison wins over a held upper output.
  override_a: assert property ( // [RULE11]
    sampleValid && critLoad && (loadValue < bottomThreshold)
    |=> !upperJudge_q && bottomJudge_q)
    else $error("Held upper output beat plain lower judgment.");

  // Plain upper comparison wins over a held lower output.
  override_up_a: assert property ( // [RULE11]
    sampleValid && critLoad && (loadValue > upperThreshold)
    |=> upperJudge_q && !bottomJudge_q)
    else $error("Held lower output beat plain upper judgment.");

  // A strobe with criterion none clears the inner outputs and the valid mark one edge later.
  crit_none_a: assert property ( // [RULE12]
    sampleValid && !critLoad
    |=> !upperJudge_q && !bottomJudge_q && !judgeValid_q)
    else $error("Judgment output active with criterion none.");

  // Criterion none clears the outer outputs as well.
  outer_none_a: assert property ( // [RULE12]
    sampleValid && !critLoad
    |=> !outerUpperJudge_q && !outerBottomJudge_q)
    else $error("Outer output active with criterion none.");

  // A strobe with the load criterion marks a judgment one edge later.
  valid_pulse_a: assert property ( // [RULE14]
    sampleValid && critLoad |=> judgeValid_q)
    else $error("Judgment mark missing after a strobe.");

  // No judgment is marked on an edge without a strobe.
  valid_idle_a: assert property ( // [RULE14]
    !sampleValid |=> !judgeValid_q)
    else $error("Judgment mark raised without a strobe.");

  // Outputs stay still between strobes.
  stable_a: assert property ( // [RULE14]
    !sampleValid |=> $stable(upperJudge_q) && $stable(bottomJudge_q))
    else $error("Judgment output changed without a strobe.");

  // Outer outputs stay still between strobes too.
  outer_stable_a: assert property ( // [RULE14]
    !sampleValid
    |=> $stable(outerUpperJudge_q) && $stable(outerBottomJudge_q))
    else $error("Outer output changed without a strobe.");
endmodule : llj_load_limit_judge
`default_nettype wire

//--- llj_cfg_model.sv
// Model of the configuring software that programs the four limits.
`default_nettype none
module llj_cfg_model (
  input  wire logic               clk_sys,
  input  wire logic               setReq,
  input  wire logic signed [23:0] center,
  input  wire logic signed [23:0] gap,
  output var  logic signed [23:0] upperThr,
  output var  logic signed [23:0] bottomThr,
  output var  logic signed [23:0] outerUpperThr,
  output var  logic signed [23:0] outerBottomThr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Limits start cleared so the judge never sees unknown values.
  initial begin
    {upperThr, bottomThr, outerUpperThr, outerBottomThr} = '0;
  end
  // A non-negative gap keeps outer bottom <= bottom <= upper <= outer upper.
  always @(posedge clk_sys) begin
    if (setReq) begin
      upperThr       <= center + gap;
      bottomThr      <= center - gap;
      outerUpperThr  <= center + (gap <<< 1);
      outerBottomThr <= center - (gap <<< 1);
    end
  end
endmodule : llj_cfg_model
`default_nettype wire

//--- llj_load_limit_judge_tb.sv
// Self-checking bench for the load limit judge.
`default_nettype none
module llj_load_limit_judge_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, sampleValid = 1'b0, setReq = 1'b1;
  logic critLoad = 1'b1, constantJudge = 1'b0, outerEnable = 1'b0;
  logic signed [23:0] loadValue = '0;
  logic signed [24:0] c = '0, g = '0, band = '0;  // Mirror of the setup.
  wire logic signed [23:0] uThr, bThr, ouThr, obThr;
  wire logic upQ, btQ, ouQ, obQ, vldQ;
  logic [3:0] exp = 4'h0;  // Expected {outerUp, up, bottom, outerBottom}.
  int fails = 0, compares = 0;
  // Hand-picked loads around every limit and release level.
  int corners[15] = '{150, 80, 70, 69, -150, -80, -70, -69, 250, 175,
                      170, 169, -250, -170, -169};
  // The clock toggles every half period of 5 ns.
  always #5 clk_sys = ~clk_sys;
  llj_cfg_model llj_cfg_model_inst (.clk_sys(clk_sys), .setReq(setReq),
    .center(c[23:0]), .gap(g[23:0]), .upperThr(uThr), .bottomThr(bThr),
    .outerUpperThr(ouThr), .outerBottomThr(obThr));
  llj_load_limit_judge llj_load_limit_judge_inst (.clk_sys(clk_sys),
    .rst(rst), .sampleValid(sampleValid), .loadValue(loadValue),
    .critLoad(critLoad), .constantJudge(constantJudge),
    .outerEnable(outerEnable), .upperThreshold(uThr),
    .bottomThreshold(bThr), .outerUpperThreshold(ouThr),
    .outerBottomThreshold(obThr), .deadbandWidth(band[23:0]),
    .upperJudge_q(upQ), .bottomJudge_q(btQ), .outerUpperJudge_q(ouQ),
    .outerBottomJudge_q(obQ), .judgeValid_q(vldQ));
  // Works out the next judgment from the previous one and a sample.
  function automatic logic [3:0] judge(input logic [3:0] p,
                                       input logic signed [24:0] v);
    logic h;
    logic [3:0] r;
    h = constantJudge && (band != 0);
    r[2] = (v > c + g) || (h && p[2] && v >= c + g - band && v >= c - g);
    r[1] = (v < c - g) || (h && p[1] && v <= c - g + band && v <= c + g);
    r[3] = outerEnable && ((v > c + 2 * g) ||
           (h && p[3] && v >= c + 2 * g - band));
    r[0] = outerEnable && ((v < c - 2 * g) ||
           (h && p[0] && v <= c - 2 * g + band));
    return r;
  endfunction : judge
  // Compares one output bit and counts the result.
  task automatic check_bit(input string name, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", name, e, s);
    end
  endtask : check_bit
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // Programs limits through the model and sets the option levels.
  task automatic configure(input int cc, gg, bb, input logic j, o, l);
    @(posedge clk_sys);
    c <= 25'(cc);
    g <= 25'(gg);
    band <= 25'(bb);
    constantJudge <= j;
    outerEnable <= o;
    critLoad <= l;
    setReq <= 1'b1;
    @(posedge clk_sys);
    setReq <= 1'b0;
    @(posedge clk_sys);
  endtask : configure
  // Sends one strobe and checks every output one cycle later.
  task automatic sample(input int v);
    @(posedge clk_sys);
    sampleValid <= 1'b1;
    loadValue <= 24'(v);
    exp = critLoad ? judge(exp, 25'(v)) : 4'h0;
    @(posedge clk_sys);
    sampleValid <= 1'b0;
    #1;
    check_bit("upperJudge_q", exp[2], upQ);
    check_bit("bottomJudge_q", exp[1], btQ);
    check_bit("outerUpperJudge_q", exp[3], ouQ);
    check_bit("outerBottomJudge_q", exp[0], obQ);
    check_bit("judgeValid_q", critLoad, vldQ);
  endtask : sample
  // Cuts a hung run short and counts it as a mismatch.
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    conclude();
  end
  // Main sequence: reset, hand-picked corners, then random traffic.
  initial begin
    void'($urandom(78));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check_bit("judgeValid_q", 1'b0, vldQ);
    configure(0, 100, 30, 1, 1, 1);
    foreach (corners[i]) begin
      sample(corners[i]);
    end
    configure(0, 100, 300, 1, 1, 1);
    sample(150); sample(-120); sample(-50); sample(120);
    configure(0, 100, 30, 0, 1, 1);
    sample(150); sample(80);
    configure(0, 100, 0, 1, 0, 1);
    sample(250); sample(99);
    configure(0, 100, 30, 1, 1, 0);
    sample(250); sample(-250);
    $display("test corners done");
    repeat (20) begin
      configure(int'($urandom_range(0, 200)) - 100, $urandom_range(0, 200),
        ($urandom_range(0, 3) == 0) ? 0 : $urandom_range(1, 150),
        1'($urandom), 1'($urandom), $urandom_range(0, 7) != 0);
      repeat (15) sample(int'($urandom_range(0, 1400)) - 700);
    end
    $display("test random done");
    conclude();
  end
endmodule : llj_load_limit_judge_tb
`default_nettype wire
